// ==== hdl/ccsc_pkg.sv ====
// Functional notes
// R1: CPU clock from speed and subclock bits
// R2: Old clock runs on after selection change
// R3: Crystal slow-to-sub within 306 clocks
// R4: RC switching 4/2/244 clock maxima
// R5: Two clocks equal one minimum instruction
// R6: Crystal reset waits 2^15 then slow
// R7: RC reset waits 2^7 then slow
// R8: Software selects high speed after supply
// R9: Software selects sub only when stable
// R10: Writing zero to stop bit restarts oscillator
// R11: Software waits stabilisation after restart
// R12: Reset gives slow mode, register 02H
// R13: Sub selected: main may stop, no STOP
// R14: Status flag reads 1 on subclock
// R15: Source changes glitch-free at instruction boundary
package ccsc_pkg;

   // ---------------------------------------------------------------
   // Register layout
   // ---------------------------------------------------------------
   localparam logic [7:0] CCSC_PROC_CTRL_RESET = 8'h02;
   localparam logic [7:0] CCSC_SUB_CTRL_RESET = 8'h00;
   localparam int CCSC_SPEED_BIT = 1;
   localparam int CCSC_MSTOP_BIT = 7;
   localparam int CCSC_SUBSEL_BIT = 4;
   localparam int CCSC_FLAG_BIT = 5;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CCSC_XTAL_WAIT_LOG2 = 15;
   localparam int CCSC_RC_WAIT_LOG2 = 7;
   localparam logic [15:0] CCSC_XTAL_WAIT = 16'h8000;
   localparam logic [15:0] CCSC_RC_WAIT = 16'h0080;
   localparam logic [15:0] CCSC_XTAL_SUB_CLOCKS = 16'h0132; // 306
   localparam logic [15:0] CCSC_RC_SUB_CLOCKS = 16'h00F4;   // 244
   localparam logic [15:0] CCSC_UP_CLOCKS = 16'h0004;
   localparam logic [15:0] CCSC_DOWN_CLOCKS = 16'h0002;
   localparam logic [15:0] CCSC_INSTR_CLOCKS = 16'h0002;
   localparam logic [3:0] CCSC_FAST_DIV = 4'h1;
   localparam logic [3:0] CCSC_SLOW_DIV = 4'h4;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CCSC_SRC_SLOW = 2'b00,
      CCSC_SRC_FAST = 2'b01,
      CCSC_SRC_SUB = 2'b10
   } ccsc_src_e;

   typedef enum logic [1:0] {
      CCSC_ST_STAB = 2'b00,
      CCSC_ST_RUN = 2'b01,
      CCSC_ST_SWITCH = 2'b10
   } ccsc_state_e;

   typedef struct packed {
      logic main_stop;
      logic speed_sel;
      logic sub_sel;
   } ccsc_ctrl_s;

endpackage

// ==== hdl/ccsc_delay_count.sv ====
`timescale 1ns/1ps
`default_nettype none
// Loadable down-counter used for switch delays and stabilisation wait
module ccsc_delay_count (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Control
   input wire logic load_i,
   input wire logic [15:0] value_i,
   input wire logic tick_i,
   // Status
   output logic done_o
);
   logic [15:0] count_reg;

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   // Counts only on ticks of the clock that was active before a switch
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         count_reg <= 16'h0000;
      end else if (load_i) begin
         count_reg <= value_i;
      end else if (tick_i && count_reg != 16'h0000) begin
         count_reg <= count_reg - 16'h0001;
      end
   end

   assign done_o = (count_reg == 16'h0000) && !load_i;
endmodule
`default_nettype wire

// ==== hdl/ccsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ccsc_top (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Oscillator ticks and options (asynchronous)
   input wire logic main_tick_i,
   input wire logic sub_tick_i,
   input wire logic sub_stable_i,
   input wire logic rc_mode_i,
   // Register writes
   input wire logic proc_ctrl_wr_i,
   input wire logic [7:0] proc_ctrl_wdata_i,
   input wire logic sub_ctrl_wr_i,
   input wire logic [7:0] sub_ctrl_wdata_i,
   // Standby request
   input wire logic stop_req_i,
   // Outputs
   output logic [7:0] proc_ctrl_rdata_o,
   output logic [7:0] sub_ctrl_rdata_o,
   output logic cpu_clk_en_o,
   output logic cpu_run_o,
   output logic main_osc_en_o,
   output logic stop_ok_o,
   output logic [1:0] cpu_src_o
);
   logic [1:0] mtick_sync_reg, stick_sync_reg, stab_sync_reg;
   logic mtick_prev_reg, stick_prev_reg, main_edge, sub_edge;
   logic rc_reg;
   logic [1:0] rc_sync_reg;
   logic [2:0] arm_reg;
   ccsc_pkg::ccsc_ctrl_s ctrl_reg;
   ccsc_pkg::ccsc_state_e state_reg;
   ccsc_pkg::ccsc_src_e src_reg, req_src;
   logic [3:0] div_reg;
   logic old_tick, cnt_load, cnt_done;
   logic [15:0] cnt_value;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Oscillator edges come from other clocks, so two stages first
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         mtick_sync_reg <= 2'b00;
         stick_sync_reg <= 2'b00;
         stab_sync_reg <= 2'b00;
         rc_sync_reg <= 2'b00;
         mtick_prev_reg <= 1'b0;
         stick_prev_reg <= 1'b0;
      end else begin
         mtick_sync_reg <= {mtick_sync_reg[0], main_tick_i};
         stick_sync_reg <= {stick_sync_reg[0], sub_tick_i};
         stab_sync_reg <= {stab_sync_reg[0], sub_stable_i};
         rc_sync_reg <= {rc_sync_reg[0], rc_mode_i};
         mtick_prev_reg <= mtick_sync_reg[1];
         stick_prev_reg <= stick_sync_reg[1];
      end
   end

   assign main_edge = mtick_sync_reg[1] && !mtick_prev_reg && !ctrl_reg.main_stop;
   assign sub_edge = stick_sync_reg[1] && !stick_prev_reg;

   // Option strap caught after release, never under reset
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rc_reg <= 1'b0;
      end else if (state_reg == ccsc_pkg::CCSC_ST_STAB) begin
         rc_reg <= rc_sync_reg[1];
      end
   end

   // Wait count reloaded until the strap has crossed both sync stages
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         arm_reg <= 3'b000;
      end else begin
         arm_reg <= {arm_reg[1:0], 1'b1};
      end
   end

   // ---------------------------------------------------------------
   // Control bits
   // ---------------------------------------------------------------
   // Reset leaves slow main mode with main oscillator running
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl_reg.main_stop <= ccsc_pkg::CCSC_PROC_CTRL_RESET[ccsc_pkg::CCSC_MSTOP_BIT]; // R12
         ctrl_reg.speed_sel <= ccsc_pkg::CCSC_PROC_CTRL_RESET[ccsc_pkg::CCSC_SPEED_BIT]; // R12
         ctrl_reg.sub_sel <= ccsc_pkg::CCSC_SUB_CTRL_RESET[ccsc_pkg::CCSC_SUBSEL_BIT];
      end else begin
         if (proc_ctrl_wr_i) begin
            ctrl_reg.speed_sel <= proc_ctrl_wdata_i[ccsc_pkg::CCSC_SPEED_BIT]; // R1
            // Stop only honoured while on subclock; writing 0 restarts
            ctrl_reg.main_stop <= proc_ctrl_wdata_i[ccsc_pkg::CCSC_MSTOP_BIT] &&
                                  src_reg == ccsc_pkg::CCSC_SRC_SUB; // R10 R13
         end
         if (sub_ctrl_wr_i) begin
            ctrl_reg.sub_sel <= sub_ctrl_wdata_i[ccsc_pkg::CCSC_SUBSEL_BIT]; // R1
         end
      end
   end

   // Requested source from the two select bits
   always_comb begin
      if (ctrl_reg.sub_sel) begin
         req_src = ccsc_pkg::CCSC_SRC_SUB; // R1
      end else if (ctrl_reg.speed_sel) begin
         req_src = ccsc_pkg::CCSC_SRC_SLOW;
      end else begin
         req_src = ccsc_pkg::CCSC_SRC_FAST;
      end
   end

   // ---------------------------------------------------------------
   // Switch delay selection
   // ---------------------------------------------------------------
   // Delay counted in ticks of the clock running before the switch
   always_comb begin
      cnt_value = ccsc_pkg::CCSC_DOWN_CLOCKS; // R5
      if (state_reg == ccsc_pkg::CCSC_ST_STAB) begin
         cnt_value = rc_sync_reg[1] ? ccsc_pkg::CCSC_RC_WAIT
                                    : ccsc_pkg::CCSC_XTAL_WAIT; // R6 R7
      end else if (req_src == ccsc_pkg::CCSC_SRC_SUB) begin
         cnt_value = rc_reg ? ccsc_pkg::CCSC_RC_SUB_CLOCKS
                            : ccsc_pkg::CCSC_XTAL_SUB_CLOCKS; // R3 R4
      end else if (src_reg == ccsc_pkg::CCSC_SRC_SLOW &&
                   req_src == ccsc_pkg::CCSC_SRC_FAST) begin
         cnt_value = ccsc_pkg::CCSC_UP_CLOCKS; // R4
      end
   end

   assign old_tick = (src_reg == ccsc_pkg::CCSC_SRC_SUB) ? sub_edge : main_edge;
   // Wait armed right after release; switch delay armed on a new request
   assign cnt_load = (state_reg == ccsc_pkg::CCSC_ST_STAB && !arm_reg[2]) ||
                     (state_reg == ccsc_pkg::CCSC_ST_RUN && req_src != src_reg); // R6 R7

   ccsc_delay_count u_delay (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .load_i(cnt_load),
      .value_i(cnt_value),
      .tick_i(old_tick),
      .done_o(cnt_done)
   );

   // ---------------------------------------------------------------
   // Source state machine
   // ---------------------------------------------------------------
   // Old source keeps running until the delay expires
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= ccsc_pkg::CCSC_ST_STAB;
         src_reg <= ccsc_pkg::CCSC_SRC_SLOW; // R12
      end else begin
         unique case (state_reg)
            ccsc_pkg::CCSC_ST_STAB: begin
               if (cnt_done && mtick_prev_reg) begin
                  state_reg <= ccsc_pkg::CCSC_ST_RUN; // R6 R7
               end
            end
            ccsc_pkg::CCSC_ST_RUN: begin
               if (req_src != src_reg) begin
                  state_reg <= ccsc_pkg::CCSC_ST_SWITCH; // R2
               end
            end
            ccsc_pkg::CCSC_ST_SWITCH: begin
               // Change only at a divider wrap so no pulse is cut short
               if (cnt_done && div_reg == 4'h0) begin
                  src_reg <= req_src; // R15
                  state_reg <= ccsc_pkg::CCSC_ST_RUN;
               end
            end
            default: state_reg <= ccsc_pkg::CCSC_ST_STAB;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // CPU clock enable generation
   // ---------------------------------------------------------------
   // Divider of the active source; enable pulse marks one CPU clock
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         div_reg <= 4'h0;
         cpu_clk_en_o <= 1'b0;
      end else if (state_reg == ccsc_pkg::CCSC_ST_STAB) begin
         div_reg <= 4'h0;
         cpu_clk_en_o <= 1'b0;
      end else if (src_reg == ccsc_pkg::CCSC_SRC_SUB) begin
         div_reg <= 4'h0;
         cpu_clk_en_o <= sub_edge;
      end else if (main_edge) begin
         if (div_reg >= ((src_reg == ccsc_pkg::CCSC_SRC_FAST) ? ccsc_pkg::CCSC_FAST_DIV
                                                              : ccsc_pkg::CCSC_SLOW_DIV)
                        - 4'h1) begin
            div_reg <= 4'h0;
            cpu_clk_en_o <= 1'b1;
         end else begin
            div_reg <= div_reg + 4'h1;
            cpu_clk_en_o <= 1'b0;
         end
      end else begin
         cpu_clk_en_o <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Status outputs
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         proc_ctrl_rdata_o <= ccsc_pkg::CCSC_PROC_CTRL_RESET;
         sub_ctrl_rdata_o <= ccsc_pkg::CCSC_SUB_CTRL_RESET;
         cpu_run_o <= 1'b0;
         main_osc_en_o <= 1'b0; // Held stopped during reset
         stop_ok_o <= 1'b0;
         cpu_src_o <= ccsc_pkg::CCSC_SRC_SLOW;
      end else begin
         proc_ctrl_rdata_o <= 8'h00;
         proc_ctrl_rdata_o[ccsc_pkg::CCSC_SPEED_BIT] <= ctrl_reg.speed_sel;
         proc_ctrl_rdata_o[ccsc_pkg::CCSC_MSTOP_BIT] <= ctrl_reg.main_stop;
         sub_ctrl_rdata_o <= 8'h00;
         sub_ctrl_rdata_o[ccsc_pkg::CCSC_SUBSEL_BIT] <= ctrl_reg.sub_sel;
         sub_ctrl_rdata_o[ccsc_pkg::CCSC_FLAG_BIT] <= (src_reg == ccsc_pkg::CCSC_SRC_SUB); // R14
         cpu_run_o <= (state_reg != ccsc_pkg::CCSC_ST_STAB);
         main_osc_en_o <= !ctrl_reg.main_stop; // R10
         stop_ok_o <= (src_reg != ccsc_pkg::CCSC_SRC_SUB); // R13
         cpu_src_o <= src_reg;
      end
   end
endmodule
`default_nettype wire

// ==== sim/ccsc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// Clock switch checker
// ---------------------------------------------
module ccsc_props (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Register writes
   input wire logic proc_ctrl_wr_i,
   input wire logic [7:0] proc_ctrl_wdata_i,
   input wire logic sub_ctrl_wr_i,
   input wire logic [7:0] sub_ctrl_wdata_i,
   // Status outputs
   input wire logic [7:0] proc_ctrl_rdata_o,
   input wire logic [7:0] sub_ctrl_rdata_o,
   input wire logic cpu_clk_en_o,
   input wire logic cpu_run_o,
   input wire logic main_osc_en_o,
   input wire logic stop_ok_o,
   input wire logic [1:0] cpu_src_o
);
   // One domain; reset blanks every check
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   // Bounds are loose: sync stages and divider wrap add a few cycles
   reset_state_a: assert property ($fell(reset_i) |-> proc_ctrl_rdata_o == 8'h02
      && cpu_src_o == 2'h0 && !main_osc_en_o && !cpu_run_o) else $error("bad reset state");
   run_sticky_a: assert property (cpu_run_o |=> cpu_run_o)
      else $error("run flag dropped");
   idle_before_run_a: assert property (!cpu_run_o |-> !cpu_clk_en_o)
      else $error("cpu clock before wait end");
   src_legal_a: assert property (cpu_src_o != 2'h3)
      else $error("illegal source code");
   old_clock_holds_a: assert property ((proc_ctrl_wr_i || sub_ctrl_wr_i)
      |=> $stable(cpu_src_o) [*2])
      else $error("source changed at once");
   up_bound_a: assert property (proc_ctrl_wr_i && !proc_ctrl_wdata_i[1] && cpu_run_o
      && cpu_src_o == 2'h0 && !sub_ctrl_rdata_o[4] |-> ##[2:80] cpu_src_o == 2'h1)
      else $error("slow to fast late");
   down_bound_a: assert property (proc_ctrl_wr_i && proc_ctrl_wdata_i[1]
      && cpu_src_o == 2'h1 && !sub_ctrl_rdata_o[4] |-> ##[2:40] cpu_src_o == 2'h0)
      else $error("fast to slow late");
   sub_return_a: assert property (sub_ctrl_wr_i && !sub_ctrl_wdata_i[4] && cpu_src_o == 2'h2
      |-> ##[2:120] cpu_src_o != 2'h2) else $error("sub return late");
   flag_follows_a: assert property ($rose(cpu_src_o == 2'h2) |-> ##[0:1] sub_ctrl_rdata_o[5])
      else $error("flag missed subclock");
   no_stop_sub_a: assert property (cpu_src_o == 2'h2 && $past(cpu_src_o) == 2'h2 |-> !stop_ok_o)
      else $error("stop allowed on subclock");
   stop_refused_a: assert property (proc_ctrl_wr_i && proc_ctrl_wdata_i[7] && cpu_src_o != 2'h2
      && !proc_ctrl_rdata_o[7] |=> !proc_ctrl_rdata_o[7] [*2]) else $error("stop taken on main");
   // Main scenarios reached
   cover property (cpu_src_o == 2'h2);
   cover property (cpu_src_o == 2'h1);
   cover property ($rose(cpu_run_o));
endmodule
`default_nettype wire

// ==== sim/ccsc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// Clock switch bench
// ---------------------------------------------
module ccsc_top_tb;
   typedef struct {logic [7:0] pval; logic [7:0] sval; logic [1:0] src; int rate;} ccsc_row_s;
   // Register values, source, CPU pulses per 320 cycles
   ccsc_row_s rows [5] = '{'{8'h00, 8'h00, 2'h1, 160}, '{8'h02, 8'h00, 2'h0, 40},
      '{8'h02, 8'h10, 2'h2, 20}, '{8'h00, 8'h00, 2'h1, 160}, '{8'h00, 8'h10, 2'h2, 20}};
   logic mclk_i = 1'h0;
   logic reset_i = 1'h1;
   logic main_tick_i = 1'h0;
   logic sub_tick_i = 1'h0;
   logic rc_mode_i = 1'h0;
   logic proc_ctrl_wr_i = 1'h0;
   logic sub_ctrl_wr_i = 1'h0;
   logic [7:0] proc_ctrl_wdata_i = 8'h02;
   logic [7:0] sub_ctrl_wdata_i = 8'h00;
   logic [7:0] proc_ctrl_rdata_o, sub_ctrl_rdata_o;
   logic cpu_clk_en_o, cpu_run_o, main_osc_en_o, stop_ok_o;
   logic [1:0] cpu_src_o;
   int error_cnt = 0;
   int num_checks = 0;
   int n;
   int p;

   // Subclock held stable by the bench, as software must ensure
   ccsc_top uut (.mclk_i(mclk_i), .reset_i(reset_i), .main_tick_i(main_tick_i),
      .sub_tick_i(sub_tick_i), .sub_stable_i(1'h1), .rc_mode_i(rc_mode_i),
      .proc_ctrl_wr_i(proc_ctrl_wr_i), .proc_ctrl_wdata_i(proc_ctrl_wdata_i),
      .sub_ctrl_wr_i(sub_ctrl_wr_i), .sub_ctrl_wdata_i(sub_ctrl_wdata_i), .stop_req_i(1'h0),
      .proc_ctrl_rdata_o(proc_ctrl_rdata_o), .sub_ctrl_rdata_o(sub_ctrl_rdata_o),
      .cpu_clk_en_o(cpu_clk_en_o), .cpu_run_o(cpu_run_o),
      .main_osc_en_o(main_osc_en_o), .stop_ok_o(stop_ok_o), .cpu_src_o(cpu_src_o));

   // System clock, 100 ns
   always #50 mclk_i = ~mclk_i;
   // Main oscillator only swings while enabled
   always @(posedge mclk_i) if (main_osc_en_o) main_tick_i <= #5 ~main_tick_i;
   // Subclock about 16 cycles, phase unrelated
   always #803 sub_tick_i = ~sub_tick_i;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s seen %h want %h", $time, m, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk_i);
      #5;
   endtask
   // Gap after a write outlasts a speed switch; switches to or from subclock are left to settle
   task automatic wr(input logic to_proc, input logic [7:0] d);
      proc_ctrl_wdata_i = d;
      sub_ctrl_wdata_i = d;
      proc_ctrl_wr_i = to_proc;
      sub_ctrl_wr_i = !to_proc;
      cyc(1);
      proc_ctrl_wr_i = 1'h0;
      sub_ctrl_wr_i = 1'h0;
      cyc(24);
   endtask
   task automatic settle(input logic [1:0] want);
      n = 0;
      while (cpu_src_o !== want && n < 4000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic wait_run();
      n = 0;
      while (cpu_run_o !== 1'h1 && n < 8000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic rate(input int exp);
      p = 0;
      repeat (320) begin
         cyc(1);
         p += (cpu_clk_en_o === 1'h1);
      end
      check(8'(p >= exp - 2 && p <= exp + 2), 8'h01, "pulse rate");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      cyc(12);
      reset_i = 1'h0;
      // Just short of two main cycles per tick over the whole wait
      cyc(2 * int'(ccsc_pkg::CCSC_XTAL_WAIT) - 16);
      check(cpu_run_o, 1'h0, "run early");
      wait_run();
      check(cpu_run_o, 1'h1, "run late");
      check(8'(n <= 64), 8'h01, "wait length");
      check(cpu_src_o, 2'h0, "start source");
      rate(40);
      $display("crystal start done");
      foreach (rows[i]) begin
         wr(1'h1, rows[i].pval);
         wr(1'h0, rows[i].sval);
         settle(rows[i].src);
         check(8'(n <= 2 * ccsc_pkg::CCSC_XTAL_SUB_CLOCKS + 16), 8'h01, "switch time");
         cyc(4);
         check(cpu_src_o, rows[i].src, "source");
         check(proc_ctrl_rdata_o, rows[i].pval, "speed readback");
         check(sub_ctrl_rdata_o, rows[i].sval | (rows[i].src == 2'h2 ? 8'h20 : 8'h00),
            "sub flag");
         check(stop_ok_o, rows[i].src != 2'h2, "stop ok");
         rate(rows[i].rate);
         $display("row %0d done", i);
      end
      // Stop main while on subclock, then restart and wait in software
      wr(1'h1, 8'h80);
      check(proc_ctrl_rdata_o, 8'h80, "stop taken");
      check(main_osc_en_o, 1'h0, "osc stopped");
      wr(1'h1, 8'h00);
      check(main_osc_en_o, 1'h1, "osc restart");
      cyc(300);
      wr(1'h0, 8'h00);
      settle(2'h1);
      check(cpu_src_o, 2'h1, "back to fast");
      wr(1'h1, 8'h80);
      check(proc_ctrl_rdata_o, 8'h00, "stop refused");
      check(main_osc_en_o, 1'h1, "osc kept");
      $display("stop test done");
      // Reset in mid-run with the RC option
      reset_i = 1'h1;
      rc_mode_i = 1'h1;
      cyc(3);
      check(proc_ctrl_rdata_o, 8'h02, "reset speed reg");
      check(main_osc_en_o, 1'h0, "osc in reset");
      check(cpu_src_o, 2'h0, "reset source");
      reset_i = 1'h0;
      cyc(2 * int'(ccsc_pkg::CCSC_RC_WAIT) - 16);
      check(cpu_run_o, 1'h0, "rc run early");
      wait_run();
      check(cpu_run_o, 1'h1, "rc run late");
      check(8'(n <= 64), 8'h01, "rc wait length");
      rate(40);
      wr(1'h0, 8'h10);
      settle(2'h2);
      check(8'(n <= 2 * ccsc_pkg::CCSC_RC_SUB_CLOCKS + 16), 8'h01, "rc sub time");
      check(cpu_src_o, 2'h2, "rc sub");
      $display("rc test done");
      close_out();
   end

   // Watchdog well past the expected run length
   initial begin
      #9500000;
      error_cnt++;
      $display("wrong value at %0t: watchdog expired", $time);
      close_out();
   end
endmodule

bind ccsc_top ccsc_props chk (.mclk_i(mclk_i), .reset_i(reset_i),
   .proc_ctrl_wr_i(proc_ctrl_wr_i), .proc_ctrl_wdata_i(proc_ctrl_wdata_i),
   .sub_ctrl_wr_i(sub_ctrl_wr_i), .sub_ctrl_wdata_i(sub_ctrl_wdata_i),
   .proc_ctrl_rdata_o(proc_ctrl_rdata_o), .sub_ctrl_rdata_o(sub_ctrl_rdata_o),
   .cpu_clk_en_o(cpu_clk_en_o),
   .cpu_run_o(cpu_run_o), .main_osc_en_o(main_osc_en_o), .stop_ok_o(stop_ok_o),
   .cpu_src_o(cpu_src_o));
`default_nettype wire
